// File: design/i2cfr_pkg.sv
// Constants, register map and types shared by the two-wire flag and data core
package i2cfr_pkg;

	// ==========================================================
	// Register map, word indices on the plain register port
	// ==========================================================
	localparam logic [2:0] I2CFR_RA_BIT_COUNT_MODE = 3'h0;
	localparam logic [2:0] I2CFR_RA_IRQ_ACK_CTRL   = 3'h1;
	localparam logic [2:0] I2CFR_RA_STATUS_FLAGS   = 3'h2;
	localparam logic [2:0] I2CFR_RA_OWN_ADDRESS    = 3'h3;
	localparam logic [2:0] I2CFR_RA_TX_HOLDING     = 3'h4;
	localparam logic [2:0] I2CFR_RA_RX_HOLDING     = 3'h5;
	localparam logic [2:0] I2CFR_RA_MODE_SELECT    = 3'h6;

	// ==========================================================
	// Field positions
	// ==========================================================
	// Bit count mode register
	localparam int I2CFR_GUARD_BIT   = 3;
	localparam logic [7:0] I2CFR_BCMR_FIXED = 8'h38; // Bits 5, 4 and guard read as one
	// Interrupt and acknowledge control register
	localparam int I2CFR_TX_EMPTY_IE = 7;
	localparam int I2CFR_TX_DONE_IE  = 6;
	localparam int I2CFR_RX_FULL_IE  = 5;
	localparam int I2CFR_NACK_IE     = 4;
	localparam int I2CFR_STOP_IE     = 3;
	localparam int I2CFR_ACK_CHECK   = 2;
	localparam int I2CFR_RX_ACK_BIT  = 1;
	localparam int I2CFR_ACK_SEND    = 0;
	localparam logic [7:0] I2CFR_CTRL_WMASK = 8'hfd;
	// Status flag register
	localparam int I2CFR_F_TX_EMPTY  = 7;
	localparam int I2CFR_F_TX_DONE   = 6;
	localparam int I2CFR_F_RX_FULL   = 5;
	localparam int I2CFR_F_NO_ACK    = 4;
	localparam int I2CFR_F_STOP      = 3;
	localparam int I2CFR_F_ARB_LOST  = 2;
	localparam int I2CFR_F_ADDR_HIT  = 1;
	localparam int I2CFR_F_GEN_CALL  = 0;
	// Mode select register
	localparam int I2CFR_MASTER_BIT  = 1;
	localparam int I2CFR_DIR_BIT     = 0;

	// ==========================================================
	// Reset values and fixed codes
	// ==========================================================
	localparam logic [7:0] I2CFR_RX_HOLD_RESET = 8'hff;
	localparam logic [7:0] I2CFR_ZERO_BYTE     = 8'h00;
	localparam logic [7:0] I2CFR_GEN_CALL_BYTE = 8'h00;
	localparam logic [2:0] I2CFR_BC_NINE       = 3'h0;
	localparam logic [3:0] I2CFR_NINE_BITS     = 4'h9;
	localparam logic [3:0] I2CFR_ONE           = 4'h1;
	localparam logic       I2CFR_SDA_LEVEL     = 1'b0; // Open drain only pulls low

	// ==========================================================
	// Operating modes from master and direction bits
	// ==========================================================
	typedef enum logic [1:0]
	{
		I2CFR_SLV_RX = 2'b00,
		I2CFR_SLV_TX = 2'b01,
		I2CFR_MST_RX = 2'b10,
		I2CFR_MST_TX = 2'b11
	} i2cfr_mode_type;

	// Bits moved by a frame for a given bit count code
	function automatic logic [3:0] i2cfr_frame_len(input logic [2:0] code);
		return (code == I2CFR_BC_NINE) ? I2CFR_NINE_BITS : ({1'b0, code} + I2CFR_ONE);
	endfunction : i2cfr_frame_len

endpackage : i2cfr_pkg

// File: design/i2cfr_core.sv
// Two-wire bus flags, interrupt requests, own address and buffered data core
//
// Functional notes
// [R1] Bit count written only when guard written 0
// [R2] Count code 000 is nine, else code+1
// [R3] Bit count returns to 000 at frame end
// [R4] Tx-empty request is empty flag and enable
// [R5] Tx-done request is done flag and enable
// [R6] Rx-full request is full flag and enable
// [R7] Nack request from no-ack or arbitration flag
// [R8] Stop request only while its enable set
// [R9] Ack check stops transfer on received one
// [R10] Received ack captured, read only
// [R11] Receive mode sends ack send value
// [R12] Tx-empty set by load, direction, start, switch
// [R13] Tx flags cleared by read-write-0 or holding write
// [R14] Tx-done set at acknowledge rise when empty
// [R15] Rx-full set on move, cleared by read
// [R16] No-ack flag set on checked nack
// [R17] Stop flag set on stop after frame
// [R18] Arbitration lost on mismatch or start seen
// [R19] Address match on own or general call
// [R20] General call flag on general call address
// [R21] Upper seven address bits compared
// [R22] Holding moves to shift when shift free
// [R23] Receive holding read only, resets to ones
// [R24] Master and direction decode four modes
// [R25] Arbitration loss falls back to slave receive
// [R26] General call is all-zero first frame
`timescale 1ns/100ps
`default_nettype none

module i2cfr_core
	import i2cfr_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       resetn_in,
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_write_in,
	input  wire logic       reg_read_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic            tx_empty_irq_out,
	output logic            tx_done_irq_out,
	output logic            rx_full_irq_out,
	output logic            nack_arb_irq_out,
	output logic            stop_seen_irq_out
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed
	{
		logic [2:0] scl_sync;
		logic       scl_lvl;
		logic [2:0] sda_sync;
		logic       sda_lvl;
		logic [2:0] bit_count_field;
		logic [7:0] ctrl;
		logic       received_ack_bit;
		logic [7:0] flags;
		logic [7:0] seen;
		logic [7:0] own_addr;
		logic [7:0] transmit_holding;
		logic       tx_hold_full;
		logic [7:0] receive_holding;
		logic [7:0] shift_register;
		logic       shift_free;
		logic [3:0] bit_index;
		logic       in_frame;
		logic       first_frame;
		logic       addressed;
		logic       master_select;
		logic       direction_select;
		logic       drive_low;
		logic [7:0] rdata;
	} i2cfr_state_type;

	i2cfr_state_type q;
	i2cfr_state_type d;

	// ==========================================================
	// Line events from the filtered levels
	// ==========================================================
	logic           scl_agree;
	logic           sda_agree;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_seen;
	logic           stop_seen;
	logic [3:0]     frame_len;
	logic           last_rise;
	logic           data_rise;
	logic           ack_slot;
	logic           active;
	logic           addr_hit;
	logic           gen_call;
	i2cfr_mode_type mode;

	// Second and third stage must agree before a level counts
	assign scl_agree  = q.scl_sync[1] == q.scl_sync[2];
	assign sda_agree  = q.sda_sync[1] == q.sda_sync[2];
	assign scl_rise   = scl_agree & q.scl_sync[2] & ~q.scl_lvl;
	assign scl_fall   = scl_agree & ~q.scl_sync[2] & q.scl_lvl;
	assign start_seen = sda_agree & ~q.sda_sync[2] & q.sda_lvl & q.scl_lvl & q.scl_sync[2];
	assign stop_seen  = sda_agree & q.sda_sync[2] & ~q.sda_lvl & q.scl_lvl & q.scl_sync[2];

	// First frame after a start is always nine bits
	assign frame_len = i2cfr_frame_len(q.first_frame ? I2CFR_BC_NINE : q.bit_count_field); // [R2]
	assign last_rise = scl_rise & q.in_frame & (4'(q.bit_index + I2CFR_ONE) == frame_len);
	assign data_rise = scl_rise & q.in_frame & ~last_rise;
	assign ack_slot  = q.bit_index == 4'(frame_len - I2CFR_ONE);
	assign mode      = i2cfr_mode_type'({q.master_select, q.direction_select}); // [R24]
	assign active    = q.master_select | q.addressed;
	assign addr_hit  = q.shift_register[7:1] == q.own_addr[7:1]; // [R21]
	assign gen_call  = q.shift_register == I2CFR_GEN_CALL_BYTE; // [R26]

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		d = q;
		// Three-stage synchronisers and agreed levels
		d.scl_sync = {q.scl_sync[1:0], scl_in};
		d.sda_sync = {q.sda_sync[1:0], sda_in};
		if (scl_agree)
		begin
			d.scl_lvl = q.scl_sync[2];
		end
		if (sda_agree)
		begin
			d.sda_lvl = q.sda_sync[2];
		end

		// Holding data enters the free shift register
		if (q.direction_select & active & q.shift_free & q.tx_hold_full & ~q.flags[I2CFR_F_NO_ACK]) // [R9]
		begin
			d.shift_register          = q.transmit_holding; // [R22]
			d.shift_free              = 1'b0;
			d.tx_hold_full            = 1'b0;
			d.flags[I2CFR_F_TX_EMPTY] = 1'b1; // [R12]
		end

		// Software reads
		d.rdata = I2CFR_ZERO_BYTE;
		if (reg_read_in)
		begin
			unique case (reg_addr_in)
				I2CFR_RA_BIT_COUNT_MODE: d.rdata = I2CFR_BCMR_FIXED | {5'h00, q.bit_count_field}; // [R1]
				I2CFR_RA_IRQ_ACK_CTRL:
				begin
					d.rdata                   = q.ctrl;
					d.rdata[I2CFR_RX_ACK_BIT] = q.received_ack_bit;
				end
				I2CFR_RA_STATUS_FLAGS:
				begin
					d.rdata = q.flags;
					d.seen  = q.flags;
				end
				I2CFR_RA_OWN_ADDRESS:    d.rdata = q.own_addr;
				I2CFR_RA_TX_HOLDING:     d.rdata = q.transmit_holding;
				I2CFR_RA_RX_HOLDING:
				begin
					d.rdata                  = q.receive_holding;
					d.flags[I2CFR_F_RX_FULL] = 1'b0; // [R15]
				end
				I2CFR_RA_MODE_SELECT:    d.rdata = {6'h00, q.master_select, q.direction_select};
				default:                 d.rdata = I2CFR_ZERO_BYTE;
			endcase
		end

		// Software writes; hardware sets below win over these clears
		if (reg_write_in)
		begin
			unique case (reg_addr_in)
				I2CFR_RA_BIT_COUNT_MODE:
				begin
					if (!reg_wdata_in[I2CFR_GUARD_BIT])
					begin
						d.bit_count_field = reg_wdata_in[2:0]; // [R1]
					end
				end
				I2CFR_RA_IRQ_ACK_CTRL:   d.ctrl = reg_wdata_in & I2CFR_CTRL_WMASK; // [R10]
				I2CFR_RA_STATUS_FLAGS:
				begin
					d.flags = d.flags & ~(~reg_wdata_in & q.seen); // [R13] [R15]
					d.flags[I2CFR_F_TX_EMPTY] |= q.shift_free & ~d.shift_free; // A load this cycle beats the clear [R12]
					d.seen  = I2CFR_ZERO_BYTE;
				end
				I2CFR_RA_OWN_ADDRESS:    d.own_addr = reg_wdata_in;
				I2CFR_RA_TX_HOLDING:
				begin
					d.transmit_holding        = reg_wdata_in;
					d.tx_hold_full            = 1'b1;
					d.flags[I2CFR_F_TX_EMPTY] = 1'b0; // [R13]
					d.flags[I2CFR_F_TX_DONE]  = 1'b0; // [R13]
				end
				I2CFR_RA_MODE_SELECT:
				begin
					d.master_select    = reg_wdata_in[I2CFR_MASTER_BIT];
					d.direction_select = reg_wdata_in[I2CFR_DIR_BIT];
					if (reg_wdata_in[I2CFR_DIR_BIT] & ~q.direction_select)
					begin
						d.flags[I2CFR_F_TX_EMPTY] = 1'b1; // [R12]
					end
				end
				default:
				begin
				end
			endcase
		end

		// Data bits shift in on each rise; the same path shifts transmit data out
		if (data_rise)
		begin
			d.bit_index      = 4'(q.bit_index + I2CFR_ONE);
			d.shift_register = {q.shift_register[6:0], q.sda_lvl};
			if ((mode == I2CFR_MST_TX) & ~q.drive_low & ~q.sda_lvl)
			begin
				d.flags[I2CFR_F_ARB_LOST] = 1'b1; // [R18]
				d.master_select           = 1'b0; // [R25]
				d.direction_select        = 1'b0; // [R25]
				d.drive_low               = 1'b0;
			end
		end

		// Acknowledge rise closes the frame
		if (last_rise)
		begin
			d.bit_index       = 4'h0;
			d.bit_count_field = I2CFR_BC_NINE; // [R3]
			d.first_frame     = 1'b0;
			d.shift_free      = 1'b1;
			if (~q.direction_select & active)
			begin
				d.receive_holding        = q.shift_register; // [R23]
				d.flags[I2CFR_F_RX_FULL] = 1'b1; // [R15]
			end
			if (q.direction_select & active)
			begin
				d.received_ack_bit = q.sda_lvl; // [R10]
				if (q.flags[I2CFR_F_TX_EMPTY])
				begin
					d.flags[I2CFR_F_TX_DONE] = 1'b1; // [R14]
				end
				if (q.ctrl[I2CFR_ACK_CHECK] & q.sda_lvl)
				begin
					d.flags[I2CFR_F_NO_ACK] = 1'b1; // [R16] [R9]
				end
			end
			if (q.first_frame & (mode == I2CFR_SLV_RX) & q.addressed)
			begin
				d.flags[I2CFR_F_ADDR_HIT] = 1'b1; // [R19]
				if (gen_call)
				begin
					d.flags[I2CFR_F_GEN_CALL] = 1'b1; // [R20]
				end
				else if (q.shift_register[0])
				begin
					d.direction_select        = 1'b1;
					d.flags[I2CFR_F_TX_EMPTY] = 1'b1; // [R12]
				end
			end
		end

		// Falling clock chooses what this device puts on the data line
		if (scl_fall & q.in_frame)
		begin
			d.drive_low = 1'b0;
			if (ack_slot)
			begin
				if (q.first_frame & (mode == I2CFR_SLV_RX) & (addr_hit | gen_call))
				begin
					d.addressed = 1'b1;
					d.drive_low = ~q.ctrl[I2CFR_ACK_SEND]; // [R11]
				end
				else if (~q.direction_select & active)
				begin
					d.drive_low = ~q.ctrl[I2CFR_ACK_SEND]; // [R11]
				end
			end
			else if (q.direction_select & active)
			begin
				d.drive_low = ~q.shift_register[7];
			end
		end

		// Start and stop conditions
		if (start_seen)
		begin
			d.in_frame    = 1'b1;
			d.first_frame = 1'b1;
			d.bit_index   = 4'h0;
			d.addressed   = 1'b0;
			d.shift_free  = 1'b1;
			if (q.master_select)
			begin
				d.flags[I2CFR_F_TX_EMPTY] = 1'b1; // [R12]
				if (~q.drive_low)
				begin
					d.flags[I2CFR_F_ARB_LOST] = 1'b1; // [R18]
					d.master_select           = 1'b0; // [R25]
					d.direction_select        = 1'b0; // [R25]
				end
			end
		end
		if (stop_seen)
		begin
			if (q.in_frame & active)
			begin
				d.flags[I2CFR_F_STOP] = 1'b1; // [R17]
			end
			d.in_frame  = 1'b0;
			d.addressed = 1'b0;
			d.drive_low = 1'b0;
			d.bit_index = 4'h0;
		end
	end

	// ==========================================================
	// State register, synchronous active-low reset
	// ==========================================================
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			q                 <= '0;
			q.scl_sync        <= 3'h7;
			q.scl_lvl         <= 1'b1;
			q.sda_sync        <= 3'h7;
			q.sda_lvl         <= 1'b1;
			q.receive_holding <= I2CFR_RX_HOLD_RESET; // [R23]
			q.shift_free      <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Interrupt requests follow flag and enable levels
	assign tx_empty_irq_out  = q.flags[I2CFR_F_TX_EMPTY] & q.ctrl[I2CFR_TX_EMPTY_IE]; // [R4]
	assign tx_done_irq_out   = q.flags[I2CFR_F_TX_DONE] & q.ctrl[I2CFR_TX_DONE_IE]; // [R5]
	assign rx_full_irq_out   = q.flags[I2CFR_F_RX_FULL] & q.ctrl[I2CFR_RX_FULL_IE]; // [R6]
	assign nack_arb_irq_out  = (q.flags[I2CFR_F_NO_ACK] | q.flags[I2CFR_F_ARB_LOST]) & q.ctrl[I2CFR_NACK_IE]; // [R7]
	assign stop_seen_irq_out = q.flags[I2CFR_F_STOP] & q.ctrl[I2CFR_STOP_IE]; // [R8]
	assign reg_rdata_out     = q.rdata;
	assign sda_out           = I2CFR_SDA_LEVEL;
	assign sda_oe_out        = q.drive_low;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking chk_clk @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);

	a_guard_reads_one: assert property ( // [R1]
		reg_read_in && reg_addr_in == I2CFR_RA_BIT_COUNT_MODE |=> reg_rdata_out[I2CFR_GUARD_BIT])
		else $error("guard bit did not read as one");
	a_guard_blocks_write: assert property ( // [R1]
		reg_write_in && reg_addr_in == I2CFR_RA_BIT_COUNT_MODE && reg_wdata_in[I2CFR_GUARD_BIT] && !last_rise
		|=> $stable(q.bit_count_field))
		else $error("bit count changed with guard set");
	a_count_returns: assert property ( // [R3]
		last_rise |=> q.bit_count_field == I2CFR_BC_NINE)
		else $error("bit count not cleared at frame end");
	a_irq_levels: assert property ( // [R4]
		tx_empty_irq_out == (q.flags[I2CFR_F_TX_EMPTY] && q.ctrl[I2CFR_TX_EMPTY_IE]))
		else $error("tx empty request mismatch");
	a_stop_irq_gate: assert property ( // [R8]
		!q.ctrl[I2CFR_STOP_IE] |-> !stop_seen_irq_out)
		else $error("stop request without enable");
	a_ack_read_only: assert property ( // [R10]
		!last_rise |=> $stable(q.received_ack_bit))
		else $error("received ack changed outside frame end");
	a_rx_read_clears: assert property ( // [R15]
		reg_read_in && reg_addr_in == I2CFR_RA_RX_HOLDING && !last_rise |=> !q.flags[I2CFR_F_RX_FULL])
		else $error("rx full not cleared by read");
	a_hold_write_clears: assert property ( // [R13]
		reg_write_in && reg_addr_in == I2CFR_RA_TX_HOLDING && !last_rise && !start_seen
		|=> !q.flags[I2CFR_F_TX_EMPTY] && !q.flags[I2CFR_F_TX_DONE])
		else $error("holding write left tx flags set");
	a_arb_fallback: assert property ( // [R25]
		$rose(q.flags[I2CFR_F_ARB_LOST]) |-> !q.master_select && !q.direction_select)
		else $error("arbitration loss kept master mode");
	a_done_needs_empty: assert property ( // [R14]
		$rose(q.flags[I2CFR_F_TX_DONE]) |-> $past(q.flags[I2CFR_F_TX_EMPTY]))
		else $error("tx done set without empty flag");

	c_frame_end: cover property (last_rise ##1 q.flags[I2CFR_F_RX_FULL]);
	c_addr_match: cover property ($rose(q.flags[I2CFR_F_ADDR_HIT]));
	c_arb_lost: cover property ($rose(q.flags[I2CFR_F_ARB_LOST]));

endmodule : i2cfr_core

`default_nettype wire

// File: verification/i2cfr_bus_master.sv
// Behavioural remote master that drives the two-wire bus clock and data lines
`timescale 1ns/100ps
`default_nettype none

module i2cfr_bus_master
(
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// ==========================================================
	// Idle bus: both lines released high, clock stands still
	// ==========================================================
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// One bit: data set mid-low, sampled mid-high, 160 ns period
	task automatic send_bit(input logic v, output logic s);
		#40 sda_low_out = !v;
		#40 scl_out = 1'b1;
		#40 s = sda_in;
		#40 scl_out = 1'b0;
	endtask : send_bit

	// Start or repeated start: data falls while clock is high
	task automatic send_start();
		sda_low_out = 1'b0;
		#40 scl_out = 1'b1;
		#80 sda_low_out = 1'b1;
		#80 scl_out = 1'b0;
	endtask : send_start

	// Stop: data rises while clock is high, then the bus idles
	task automatic send_stop();
		#40 sda_low_out = 1'b1;
		#40 scl_out = 1'b1;
		#80 sda_low_out = 1'b0;
		#80;
	endtask : send_stop

	// Byte MSB first, then release the line and sample the acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(b[i], s);
		send_bit(1'b1, ack);
		#120;
	endtask : send_byte

endmodule : i2cfr_bus_master

`default_nettype wire

// File: verification/test_i2c_flags_irq_and_data_regs.sv
// Self-checking testbench of the two-wire flag and data core
`timescale 1ns/100ps
`default_nettype none

module test_i2c_flags_irq_and_data_regs;
	import i2cfr_pkg::*;

	logic       clock_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic       reg_write_in = 1'b0;
	logic       reg_read_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic       scl_wire;
	logic       sda_wire;
	logic       sda_out;
	logic       sda_oe_out;
	logic       m_sda_low;
	logic [4:0] irq;
	logic       ack;
	int         err_count = 0;
	int         comparisons = 0;

	// ==========================================================
	// Clock, wired-AND data line with pull-up, design and far side
	// ==========================================================
	always #10 clock_in = !clock_in;
	assign sda_wire = (sda_oe_out ? sda_out : 1'b1) & !m_sda_low;

	i2cfr_core DUT (.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .scl_in(scl_wire), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .tx_empty_irq_out(irq[4]), .tx_done_irq_out(irq[3]),
		.rx_full_irq_out(irq[2]), .nack_arb_irq_out(irq[1]), .stop_seen_irq_out(irq[0]));

	i2cfr_bus_master u_far (.sda_in(sda_wire), .scl_out(scl_wire), .sda_low_out(m_sda_low));

	// ==========================================================
	// Register port tasks and comparison
	// ==========================================================
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
		#1;
	endtask : wr

	// Read a register and compare the masked value
	task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		#1 chk(w, e, reg_rdata_out & m);
	endtask : rdchk

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Ordinary register cases: write, then read back
	logic [2:0] row_a[8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h5, 3'h7};
	logic [7:0] row_w[8] = '{8'h05, 8'h0e, 8'h00, 8'hff, 8'h00, 8'ha8, 8'h00, 8'h12};
	logic [7:0] row_e[8] = '{8'h3d, 8'h3d, 8'h38, 8'hfd, 8'h00, 8'ha8, 8'hff, 8'h00};
	logic [2:0] rst_a[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [7:0] rst_e[7] = '{8'h38, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial
	begin
		repeat (20) @(posedge clock_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		for (int i = 0; i < 7; i++)
			rdchk(rst_a[i], 8'hff, rst_e[i], "reset value");
		chk("irqs after reset", 8'h00, {3'h0, irq});
		$display("test reset done");

		for (int i = 0; i < 8; i++)
		begin
			wr(row_a[i], row_w[i]);
			rdchk(row_a[i], 8'hff, row_e[i], "register row");
		end
		$display("test register rows done");

		// Direction set raises tx-empty; clears by read-write-0 and holding write
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h80);
		wr(I2CFR_RA_MODE_SELECT, 8'h01);
		rdchk(I2CFR_RA_MODE_SELECT, 8'h03, 8'h01, "mode");
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h80, 8'h80, "tx empty set");
		chk("tx empty irq", 8'h01, {7'h0, irq[4]});
		wr(I2CFR_RA_STATUS_FLAGS, 8'h7f);
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h80, 8'h00, "tx empty cleared");
		chk("tx empty irq off", 8'h00, {7'h0, irq[4]});
		wr(I2CFR_RA_MODE_SELECT, 8'h00);
		wr(I2CFR_RA_MODE_SELECT, 8'h01);
		wr(I2CFR_RA_TX_HOLDING, 8'h5a);
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h80, 8'h00, "tx empty after load");
		rdchk(I2CFR_RA_TX_HOLDING, 8'hff, 8'h5a, "tx holding");
		wr(I2CFR_RA_MODE_SELECT, 8'h00);
		$display("test transmit flags done");

		// Addressed slave receive, acknowledged low and then high
		wr(I2CFR_RA_OWN_ADDRESS, 8'ha8);
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h20);
		u_far.send_start();
		u_far.send_byte(8'ha8, ack);
		chk("address ack", 8'h00, {7'h0, ack});
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h23, 8'h22, "address match");
		chk("rx full irq", 8'h01, {7'h0, irq[2]});
		rdchk(I2CFR_RA_RX_HOLDING, 8'hff, 8'ha8, "rx holding");
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h20, 8'h00, "rx full after read");
		chk("rx full irq off", 8'h00, {7'h0, irq[2]});
		rdchk(I2CFR_RA_BIT_COUNT_MODE, 8'hff, 8'h38, "bit count after frame");
		// Short frame of four bits, count set while the clock is low
		wr(I2CFR_RA_BIT_COUNT_MODE, 8'h03);
		for (int i = 0; i < 4; i++)
			u_far.send_bit(i[0], ack);
		#120;
		rdchk(I2CFR_RA_BIT_COUNT_MODE, 8'hff, 8'h38, "bit count after short");
		rdchk(I2CFR_RA_RX_HOLDING, 8'h00, 8'h00, "drain holding");
		u_far.send_byte(8'h3c, ack);
		chk("data ack low", 8'h00, {7'h0, ack});
		rdchk(I2CFR_RA_RX_HOLDING, 8'hff, 8'h3c, "rx data");
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h01);
		u_far.send_byte(8'h3c, ack);
		chk("data ack high", 8'h01, {7'h0, ack});
		u_far.send_stop();
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h08, 8'h08, "stop flag");
		chk("stop irq masked", 8'h00, {7'h0, irq[0]});
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h09);
		chk("stop irq", 8'h01, {7'h0, irq[0]});
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h0a, 8'h0a, "flags before clear");
		wr(I2CFR_RA_STATUS_FLAGS, 8'h00);
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h7f, 8'h00, "flags cleared");
		chk("stop irq off", 8'h00, {7'h0, irq[0]});
		$display("test slave receive done");

		// General call answered with the high acknowledge value
		u_far.send_start();
		u_far.send_byte(8'h00, ack);
		chk("general call ack", 8'h01, {7'h0, ack});
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h03, 8'h03, "general call");
		wr(I2CFR_RA_STATUS_FLAGS, 8'h00);
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h03, 8'h00, "general call cleared");
		rdchk(I2CFR_RA_RX_HOLDING, 8'h00, 8'h00, "drain holding");
		// Foreign address: no acknowledge, no flags
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h00);
		u_far.send_start();
		u_far.send_byte(8'h22, ack);
		chk("foreign ack", 8'h01, {7'h0, ack});
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h23, 8'h00, "foreign flags");
		u_far.send_stop();
		$display("test address decode done");

		// Foreign start while in master mode: arbitration lost, fall back to slave receive
		wr(I2CFR_RA_IRQ_ACK_CTRL, 8'h10);
		wr(I2CFR_RA_MODE_SELECT, 8'h03);
		rdchk(I2CFR_RA_MODE_SELECT, 8'h03, 8'h03, "master transmit mode");
		u_far.send_start();
		rdchk(I2CFR_RA_STATUS_FLAGS, 8'h04, 8'h04, "arbitration lost");
		rdchk(I2CFR_RA_MODE_SELECT, 8'h03, 8'h00, "mode after loss");
		chk("nack arb irq", 8'h01, {7'h0, irq[1]});
		wr(I2CFR_RA_STATUS_FLAGS, 8'h00);
		chk("nack arb irq off", 8'h00, {7'h0, irq[1]});
		u_far.send_stop();
		$display("test arbitration done");
		end_sim();
	end

	// Watchdog: the run needs well under 100 us
	initial
	begin
		#200_000;
		err_count++;
		$display("watchdog expired");
		end_sim();
	end

endmodule : test_i2c_flags_irq_and_data_regs

`default_nettype wire
